// File: logic/pdcl_pkg.sv
// Package of constants shared by the pulse drive command logic.
package pdcl_pkg;
  localparam logic [2:0] ADDR_COMMAND_WORD = 3'h0;
  localparam logic [2:0] ADDR_MAIN_STATUS = 3'h1;
  localparam logic [2:0] ADDR_READ_DATA_LOW = 3'h2;
  localparam logic [2:0] ADDR_READ_DATA_HIGH = 3'h3;
  localparam logic [2:0] ADDR_TARGET_LOW = 3'h4;
  localparam logic [2:0] ADDR_TARGET_HIGH = 3'h5;
  localparam logic [2:0] ADDR_CONFIG = 3'h6;
  localparam logic [2:0] ADDR_SPLIT_SET = 3'h7;

  localparam logic [7:0] CMD_SPLIT_READ = 8'h47;
  localparam logic [7:0] CMD_REL_DRIVE = 8'h50;
  localparam logic [7:0] CMD_CREL_DRIVE = 8'h51;
  localparam logic [7:0] CMD_PLUS_CONT = 8'h52;
  localparam logic [7:0] CMD_MINUS_CONT = 8'h53;
  localparam logic [7:0] CMD_ABS_DRIVE = 8'h54;
  localparam logic [7:0] CMD_DEC_STOP = 8'h56;
  localparam logic [7:0] CMD_INST_STOP = 8'h57;
  localparam logic [7:0] CMD_DIR_PLUS = 8'h58;
  localparam logic [7:0] CMD_DIR_MINUS = 8'h59;
  localparam logic [7:0] CMD_HOME_SEARCH = 8'h5A;
  localparam logic [3:0] LINK_ENABLE = 4'h8;
  localparam logic [3:0] LINK_DISABLE = 4'h9;
  localparam logic [3:0] LINK_ACTIVATE = 4'hA;

  localparam int CFG_ONE_PULSE_BIT = 0;
  localparam int CFG_IN_POSITION_INPUT_EN_BIT = 1;
  localparam int CFG_IN_POSITION_INPUT_LEVEL_BIT = 2;
  localparam int CFG_EXT_STOP_EN_BIT = 3;
  localparam int STAT_DRIVE_BIT = 0;
  localparam int STAT_HOME_BIT = 1;
  localparam int STAT_LINK_LSB = 4;

  localparam logic [15:0] PERIOD_RESET = 16'h0004;
  localparam logic [15:0] SPLIT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    PDCL_IDLE = 2'b00,
    PDCL_SETTLE = 2'b01,
    PDCL_RUN = 2'b10,
    PDCL_WAIT_POS = 2'b11
  } pdcl_state_t;
endpackage : pdcl_pkg

// File: logic/pdcl_rate_gen.sv
// Pulse rate divider giving a one-cycle step enable.
`timescale 1ns/10ps
module pdcl_rate_gen
  import pdcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic [15:0] i_period,
  output logic o_step
);
  logic [15:0] count;

  // Step fires on the first run cycle so the first pulse is not delayed a whole period.
  always_ff @(posedge i_mclk) begin
    if (i_srst || !i_run) begin
      count <= 16'h0000;
    end else if (count >= i_period) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

  assign o_step = i_run && (count == 16'h0000);
endmodule : pdcl_rate_gen

// File: logic/pdcl_top.sv
// Pulse drive command logic: command decode, drive sequencing and readback.
`timescale 1ns/10ps
module pdcl_top
  import pdcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_in_position_input,
  input wire logic i_ext_stop,
  input wire logic [3:0] i_link_load,
  input wire logic [31:0] i_general_holding_register,
  output logic o_plus_pulse_output,
  output logic o_minus_pulse_output,
  output logic o_heading,
  output logic [3:0] o_link_activate,
  output logic [31:0] o_logical_position
);
  pdcl_state_t state;
  pdcl_state_t next_state;
  logic [31:0] target_count_or_endpoint;
  logic [15:0] config_bits;
  logic [15:0] start_period;
  logic [15:0] period;
  logic [15:0] split_length;
  logic [15:0] pulse_width;
  logic [31:0] read_data;
  logic [31:0] remaining;
  logic continuous;
  logic minus_dir;
  logic decel;
  logic home_search;
  logic [3:0] link_enabled;
  logic step;
  logic pulse_hi;
  logic cmd_wr;
  logic [7:0] cmd;
  logic is_drive_cmd;
  logic stop_now;
  logic pos_ok;
  logic [31:0] cmd_count;
  logic cmd_minus;

  assign cmd_wr = i_wr && (i_addr == ADDR_COMMAND_WORD);
  assign cmd = i_wdata[7:0];
  assign pos_ok = i_in_position_input == config_bits[CFG_IN_POSITION_INPUT_LEVEL_BIT];

  // Signed counts are turned into a magnitude and a heading at command time.
  always_comb begin
    cmd_count = target_count_or_endpoint;
    cmd_minus = 1'b0;
    is_drive_cmd = 1'b0;
    unique case (cmd)
      CMD_REL_DRIVE: begin
        is_drive_cmd = 1'b1;
        cmd_minus = target_count_or_endpoint[31];
      end
      CMD_CREL_DRIVE: begin
        is_drive_cmd = 1'b1;
        cmd_minus = !target_count_or_endpoint[31];
      end
      CMD_ABS_DRIVE: begin
        is_drive_cmd = 1'b1;
        cmd_count = target_count_or_endpoint - o_logical_position;
        cmd_minus = cmd_count[31];
      end
      CMD_PLUS_CONT, CMD_HOME_SEARCH: begin
        is_drive_cmd = 1'b1;
      end
      CMD_MINUS_CONT: begin
        is_drive_cmd = 1'b1;
        cmd_minus = 1'b1;
      end
      default: begin
        is_drive_cmd = 1'b0;
      end
    endcase
    // The magnitude follows the sign of the count itself, so a counter-relative move of a negative count stays short.
    if (cmd_count[31]) begin
      cmd_count = 32'h0000_0000 - cmd_count;
    end
    if (i_wdata[15:8] != 8'h00) begin
      is_drive_cmd = 1'b0;
    end
  end

  assign stop_now = (state == PDCL_RUN) && ((cmd_wr && cmd == CMD_INST_STOP) ||
    (config_bits[CFG_EXT_STOP_EN_BIT] && i_ext_stop) ||
    (decel && step && period >= start_period) ||
    (!continuous && step && remaining <= 32'h0000_0001));

  always_comb begin
    next_state = state;
    unique case (state)
      PDCL_IDLE: begin
        if (cmd_wr && is_drive_cmd) begin
          next_state = PDCL_SETTLE;
        end
      end
      PDCL_SETTLE: begin
        next_state = PDCL_RUN;
      end
      PDCL_RUN: begin
        if (stop_now) begin
          next_state = config_bits[CFG_IN_POSITION_INPUT_EN_BIT] ? PDCL_WAIT_POS : PDCL_IDLE;
        end
      end
      PDCL_WAIT_POS: begin
        if (pos_ok) begin
          next_state = PDCL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= PDCL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Drive setup on start; a zero count finishes on its first step without a pulse.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      remaining <= 32'h0000_0000;
      continuous <= 1'b0;
      minus_dir <= 1'b0;
      home_search <= 1'b0;
    end else if (state == PDCL_IDLE && cmd_wr && is_drive_cmd) begin
      remaining <= cmd_count;
      continuous <= (cmd == CMD_PLUS_CONT) || (cmd == CMD_MINUS_CONT) || (cmd == CMD_HOME_SEARCH);
      minus_dir <= cmd_minus;
      home_search <= cmd == CMD_HOME_SEARCH;
    end else if (state == PDCL_RUN && step && remaining != 32'h0000_0000) begin
      remaining <= remaining - 32'h0000_0001;
    end else if (state == PDCL_IDLE) begin
      home_search <= 1'b0;
    end
  end

  // Heading is presettable only while idle and follows the drive once started.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_heading <= 1'b0;
    end else if (state == PDCL_IDLE && cmd_wr && is_drive_cmd) begin
      o_heading <= cmd_minus;
    end else if (state == PDCL_IDLE && cmd_wr && cmd == CMD_DIR_PLUS && i_wdata[15:8] == 8'h00) begin
      o_heading <= 1'b0;
    end else if (state == PDCL_IDLE && cmd_wr && cmd == CMD_DIR_MINUS && i_wdata[15:8] == 8'h00) begin
      o_heading <= 1'b1;
    end
  end

  // Simple ramp: a decelerating stop ends on the next step, as period already equals start_period (both load PERIOD_RESET).
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      decel <= 1'b0;
      period <= PERIOD_RESET;
    end else if (state != PDCL_RUN) begin
      decel <= 1'b0;
      period <= PERIOD_RESET;
    end else begin
      if (cmd_wr && cmd == CMD_DEC_STOP) begin
        decel <= 1'b1;
      end
      if (decel && step) begin
        period <= period + 16'h0001;
      end
    end
  end

  pdcl_rate_gen u_rate (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_run(state == PDCL_RUN),
    .i_period(period),
    .o_step(step)
  );

  assign pulse_hi = step && (continuous || remaining != 32'h0000_0000);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_plus_pulse_output <= 1'b0;
      o_minus_pulse_output <= 1'b0;
    end else begin
      o_plus_pulse_output <= pulse_hi && (config_bits[CFG_ONE_PULSE_BIT] || !minus_dir);
      o_minus_pulse_output <= pulse_hi && !config_bits[CFG_ONE_PULSE_BIT] && minus_dir;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_logical_position <= 32'h0000_0000;
    end else if (pulse_hi) begin
      o_logical_position <= minus_dir ? o_logical_position - 32'h0000_0001 : o_logical_position + 32'h0000_0001;
    end
  end

  // Linked action decode; the activate pulse is gated by the enable state.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      link_enabled <= 4'h0;
      o_link_activate <= 4'h0;
    end else begin
      o_link_activate <= 4'h0;
      if (cmd_wr && i_wdata[15:8] == 8'h00) begin
        if (i_wdata[7:4] == LINK_ENABLE) begin
          link_enabled <= link_enabled | i_wdata[3:0];
        end else if (i_wdata[7:4] == LINK_DISABLE) begin
          link_enabled <= link_enabled & ~i_wdata[3:0];
        end else if (i_wdata[7:4] == LINK_ACTIVATE) begin
          o_link_activate <= link_enabled & i_wdata[3:0];
        end
      end
    end
  end

  // Configuration, target and split settings; a linked load overrides a host write.
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      target_count_or_endpoint <= 32'h0000_0000;
      config_bits <= 16'h0000;
      start_period <= PERIOD_RESET;
      split_length <= SPLIT_RESET;
      pulse_width <= SPLIT_RESET;
    end else begin
      if (i_wr && i_addr == ADDR_TARGET_LOW) begin
        target_count_or_endpoint[15:0] <= i_wdata;
      end
      if (i_wr && i_addr == ADDR_TARGET_HIGH) begin
        target_count_or_endpoint[31:16] <= i_wdata;
      end
      if (i_wr && i_addr == ADDR_CONFIG) begin
        config_bits <= i_wdata;
      end
      if (i_wr && i_addr == ADDR_SPLIT_SET) begin
        split_length <= i_wdata;
        pulse_width <= i_wdata;
      end
      if (|(i_link_load & link_enabled)) begin
        split_length <= i_general_holding_register[15:0];
        pulse_width <= i_general_holding_register[31:16];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      read_data <= 32'h0000_0000;
    end else if (cmd_wr && cmd == CMD_SPLIT_READ && i_wdata[15:8] == 8'h00) begin
      read_data <= {pulse_width, split_length};
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        ADDR_MAIN_STATUS: begin
          o_rdata <= {8'h00, link_enabled, 2'b00, home_search, state != PDCL_IDLE};
        end
        ADDR_READ_DATA_LOW: begin
          o_rdata <= read_data[15:0];
        end
        ADDR_READ_DATA_HIGH: begin
          o_rdata <= read_data[31:16];
        end
        ADDR_CONFIG: begin
          o_rdata <= config_bits;
        end
        default: begin
          o_rdata <= 16'h0000;
        end
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  chk_drive_flag_start: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state == PDCL_IDLE && cmd_wr && is_drive_cmd) |=> state == PDCL_SETTLE)
    else $error("drive did not start");
  chk_first_pulse_gap: assert property (@(posedge i_mclk) disable iff (i_srst)
    state == PDCL_SETTLE |=> state == PDCL_RUN && step ##1 (o_plus_pulse_output || o_minus_pulse_output || remaining == 0))
    else $error("first pulse late");
  chk_in_position_input_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state == PDCL_WAIT_POS && !pos_ok) |=> state == PDCL_WAIT_POS)
    else $error("motion flag dropped early");
  chk_inst_stop: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state == PDCL_RUN && cmd_wr && cmd == CMD_INST_STOP) |=> state != PDCL_RUN)
    else $error("instant stop missed");
  chk_stop_ignored: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state == PDCL_IDLE && cmd_wr && (cmd == CMD_INST_STOP || cmd == CMD_DEC_STOP)) |=> state == PDCL_IDLE)
    else $error("stop acted while idle");
  chk_pos_count: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_plus_pulse_output && !config_bits[CFG_ONE_PULSE_BIT] |-> o_logical_position == $past(o_logical_position) + 1)
    else $error("position not counted up");
  chk_minus_cont: assert property (@(posedge i_mclk) disable iff (i_srst)
    (state == PDCL_IDLE && cmd_wr && is_drive_cmd && cmd == CMD_MINUS_CONT) |=> ##1 minus_dir && continuous)
    else $error("minus drive setup wrong");
  chk_split_read: assert property (@(posedge i_mclk) disable iff (i_srst)
    (cmd_wr && cmd == CMD_SPLIT_READ && i_wdata[15:8] == 0) |=> read_data == {$past(pulse_width), $past(split_length)})
    else $error("split readback wrong");
  chk_link_enable: assert property (@(posedge i_mclk) disable iff (i_srst)
    (cmd_wr && i_wdata[15:4] == 12'h008) |=> (link_enabled & $past(i_wdata[3:0])) == $past(i_wdata[3:0]))
    else $error("link enable lost");
endmodule : pdcl_top

// File: dv/pdcl_host.sv
// Host model that drives the register port of the pulse drive command logic.
`timescale 1ns/10ps
module pdcl_host
  import pdcl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [15:0] i_rdata,
  output logic [2:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial begin
    o_addr = 3'h0;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // The spare edge before each strobe keeps command writes two cycles apart.
  task automatic wr(input logic [2:0] a, input logic [15:0] dat);
    @(posedge i_mclk);
    o_addr <= a;
    o_wdata <= dat;
    o_wr <= 1'b1;
    @(posedge i_mclk);
    o_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] dat);
    @(posedge i_mclk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_mclk);
    o_rd <= 1'b0;
    #1;
    dat = i_rdata;
  endtask : rd

  // The target is always loaded before the command that uses it.
  task automatic drive(input logic [31:0] t, input logic [7:0] c);
    wr(ADDR_TARGET_LOW, t[15:0]);
    wr(ADDR_TARGET_HIGH, t[31:16]);
    wr(ADDR_COMMAND_WORD, {8'h00, c});
  endtask : drive

  task automatic link(input logic [3:0] op, input logic [3:0] sets);
    wr(ADDR_COMMAND_WORD, {8'h00, op, sets});
  endtask : link
endmodule : pdcl_host

// File: dv/pulse_drive_command_logic_tb.sv
// Self-checking bench for the pulse drive command logic.
`timescale 1ns/10ps
module pulse_drive_command_logic_tb;
  import pdcl_pkg::*;
  logic i_mclk, i_srst, i_wr, i_rd, i_in_position_input, i_ext_stop;
  logic [2:0] i_addr;
  logic [15:0] i_wdata, o_rdata, d, d2;
  logic [3:0] i_link_load, o_link_activate, act_seen, en;
  logic [31:0] i_general_holding_register, o_logical_position, v;
  logic o_plus_pulse_output, o_minus_pulse_output, o_heading, heading_d;
  logic [7:0] cont_c [3] = '{CMD_PLUS_CONT, CMD_MINUS_CONT, CMD_HOME_SEARCH};
  logic [7:0] stop_c [3] = '{CMD_DEC_STOP, 8'h00, CMD_INST_STOP};
  int fail_count, check_count, n_plus, n_minus, exp_pos, n0, t;

  pdcl_top DUT (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_in_position_input(i_in_position_input), .i_ext_stop(i_ext_stop),
    .i_link_load(i_link_load), .i_general_holding_register(i_general_holding_register),
    .o_plus_pulse_output(o_plus_pulse_output), .o_minus_pulse_output(o_minus_pulse_output),
    .o_heading(o_heading), .o_link_activate(o_link_activate), .o_logical_position(o_logical_position));
  pdcl_host host (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr),
    .o_rd(i_rd));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Pulse counters run on every edge; the heading hold check runs on each edge with a plus pulse.
  always @(posedge i_mclk) begin
    n_plus += int'(o_plus_pulse_output === 1'b1);
    n_minus += int'(o_minus_pulse_output === 1'b1);
    if (o_plus_pulse_output === 1'b1) begin
      check(o_heading, heading_d);
    end
    heading_d = o_heading;
    act_seen = act_seen | o_link_activate;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (30000) @(posedge i_mclk);
    fail_count++;
    give_verdict();
  end

  task automatic wait_idle();
    int k;
    k = 0;
    d = 16'h0001;
    while (d[STAT_DRIVE_BIT] !== 1'b0 && k < 300) begin
      host.rd(ADDR_MAIN_STATUS, d);
      k++;
    end
    check(d[STAT_DRIVE_BIT], 1'b0);
  endtask : wait_idle

  // A signed move of mv pulses is expected from every fixed drive.
  task automatic run_fix(input logic [7:0] c, input int tgt, input int mv);
    n_plus = 0;
    n_minus = 0;
    host.drive(tgt, c);
    host.rd(ADDR_MAIN_STATUS, d);
    check(d[STAT_DRIVE_BIT], 1'b1);
    wait_idle();
    exp_pos += mv;
    check(o_logical_position, exp_pos);
    check(mv > 0 ? n_plus : n_minus, mv > 0 ? mv : -mv);
    check(mv > 0 ? n_minus : n_plus, 0);
  endtask : run_fix

  initial begin
    {i_srst, i_in_position_input, i_ext_stop, i_link_load, i_general_holding_register} = '0;
    act_seen = 4'h0;
    i_srst = 1'b1;
    v = $urandom(32'hb947edb5);
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    host.rd(ADDR_MAIN_STATUS, d);
    check(d, 16'h0000);
    host.rd(ADDR_TARGET_LOW, d);
    check(d, 16'h0000);
    $display("test reset done");
    t = 2 + int'($urandom_range(7));
    run_fix(CMD_REL_DRIVE, t, t);
    run_fix(CMD_REL_DRIVE, -t, -t);
    run_fix(CMD_CREL_DRIVE, t, -t);
    run_fix(CMD_CREL_DRIVE, -t, t);
    run_fix(CMD_ABS_DRIVE, t, t);
    run_fix(CMD_ABS_DRIVE, -3, -3 - exp_pos);
    run_fix(CMD_REL_DRIVE, 0, 0);
    $display("test fixed drives done");
    n_plus = 0;
    n_minus = 0;
    host.wr(ADDR_COMMAND_WORD, {8'h00, CMD_INST_STOP});
    host.wr(ADDR_COMMAND_WORD, {8'h00, CMD_DEC_STOP});
    host.rd(ADDR_MAIN_STATUS, d);
    check(n_plus + n_minus + d[STAT_DRIVE_BIT], 0);
    host.wr(ADDR_CONFIG, 16'h0008);
    for (int i = 0; i < 3; i++) begin
      n_plus = 0;
      n_minus = 0;
      host.drive(32'h0, cont_c[i]);
      repeat (30) @(posedge i_mclk);
      host.rd(ADDR_MAIN_STATUS, d);
      check(d[STAT_HOME_BIT], i == 2);
      n0 = n_plus + n_minus;
      if (stop_c[i] == 8'h00) begin
        @(posedge i_mclk);
        i_ext_stop <= 1'b1;
      end else begin
        host.wr(ADDR_COMMAND_WORD, {8'h00, stop_c[i]});
      end
      repeat (12) @(posedge i_mclk);
      check(n_plus + n_minus - n0 <= 2, 1'b1);
      wait_idle();
      @(posedge i_mclk);
      i_ext_stop <= 1'b0;
      exp_pos += n_plus - n_minus;
      check(o_logical_position, exp_pos);
      check(i == 1 ? n_plus : n_minus, 0);
      check(n0 > 0, 1'b1);
    end
    $display("test continuous done");
    host.wr(ADDR_CONFIG, 16'h0006);
    n_plus = 0;
    host.drive(32'd2, CMD_REL_DRIVE);
    repeat (60) @(posedge i_mclk);
    host.rd(ADDR_MAIN_STATUS, d);
    check(d[STAT_DRIVE_BIT], 1'b1);
    check(n_plus, 2);
    @(posedge i_mclk);
    i_in_position_input <= 1'b1;
    wait_idle();
    exp_pos += 2;
    $display("test in-position done");
    host.wr(ADDR_CONFIG, 16'h0001);
    host.wr(ADDR_COMMAND_WORD, {8'h00, CMD_DIR_MINUS});
    @(posedge i_mclk);
    check(o_heading, 1'b1);
    host.wr(ADDR_COMMAND_WORD, {8'h00, CMD_DIR_PLUS});
    @(posedge i_mclk);
    check(o_heading, 1'b0);
    n_plus = 0;
    n_minus = 0;
    host.drive(32'd3, CMD_CREL_DRIVE);
    host.rd(ADDR_MAIN_STATUS, d);
    check(d[STAT_DRIVE_BIT], 1'b1);
    wait_idle();
    check(n_minus, 0);
    exp_pos -= 3;
    check(o_logical_position, exp_pos);
    check(n_plus, 3);
    check(o_heading, 1'b1);
    $display("test one-pulse done");
    en = 4'($urandom) | 4'h1;
    host.link(LINK_ENABLE, 4'hF);
    host.link(LINK_DISABLE, ~en);
    host.wr(ADDR_COMMAND_WORD, {8'h01, LINK_ENABLE, 4'hF});
    host.rd(ADDR_MAIN_STATUS, d);
    check(d[STAT_LINK_LSB +: 4], en);
    act_seen = 4'h0;
    host.link(LINK_ACTIVATE, 4'hF);
    repeat (3) @(posedge i_mclk);
    check(act_seen, en);
    host.wr(ADDR_SPLIT_SET, v[15:0]);
    host.wr(ADDR_COMMAND_WORD, {8'h00, CMD_SPLIT_READ});
    host.rd(ADDR_READ_DATA_LOW, d);
    host.rd(ADDR_READ_DATA_HIGH, d2);
    check({d2, d}, {v[15:0], v[15:0]});
    v = $urandom;
    @(posedge i_mclk);
    i_general_holding_register <= v;
    i_link_load <= en;
    @(posedge i_mclk);
    i_link_load <= 4'h0;
    host.wr(ADDR_COMMAND_WORD, {8'h00, CMD_SPLIT_READ});
    host.rd(ADDR_READ_DATA_LOW, d);
    host.rd(ADDR_READ_DATA_HIGH, d2);
    check({d2, d}, v);
    $display("test link and split done");
    give_verdict();
  end
endmodule : pulse_drive_command_logic_tb
